// ### ppm_pin_mux.sv
// peripheral pin multiplexer: four control words on avalon-mm, per-pin priority
// resolution of spi, i2c, uarts, comparator, analog, pulse outputs and gpio.
// assumes pin_in arrives asynchronously; peripheral and gpio drives are on mclk.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
module ppm_pin_mux (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] pin_in,
   input wire logic [3:0] capture3_alt_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic [1:0] amp_pin_out,
   output logic [1:0] amp_pin_oe,
   input wire logic [31:0] gpio_out,
   input wire logic [31:0] gpio_oe,
   input wire logic [31:0] analog_claim,
   input wire logic spi_cs_out,
   input wire logic spi_cs_oe,
   input wire logic spi_ck_out,
   input wire logic spi_ck_oe,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe,
   input wire logic spi_mosi_out,
   input wire logic spi_mosi_oe,
   output logic spi_cs_in,
   output logic spi_ck_in,
   output logic spi_miso_in,
   output logic spi_mosi_in,
   input wire logic i2c_scl_drive_low,
   input wire logic i2c_sda_drive_low,
   output logic i2c_scl_in,
   output logic i2c_sda_in,
   input wire logic uart_tx,
   output logic uart_rx,
   input wire logic uart_two_tx,
   output logic uart_two_rx,
   input wire logic comparator_out,
   input wire logic amp_digital_out,
   input wire logic [3:0] pulse_out,
   output logic capture_input_one,
   output logic capture_input_two,
   output logic capture_input_three
);

   logic [31:0] mux_control_capture_pulse_lo;
   logic [31:0] mux_control_serial_ports;
   logic [31:0] mux_control_capture_pulse_hi;
   logic [31:0] mux_control_second_uart;
   logic [31:0] next_capture_pulse_lo;
   logic [31:0] next_serial_ports;
   logic [31:0] next_capture_pulse_hi;
   logic [31:0] next_second_uart;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic [31:0] rd_mux;
   logic bus_req;
   logic wr_go;

   // register bus: every access answers on the second edge
   function automatic logic [31:0] ppm_masked_write(
      input logic [31:0] old_val,
      input logic [31:0] wd,
      input logic [3:0] be,
      input logic [31:0] wmask
   );
      logic [31:0] upd;
      upd = 32'h00000000;
      if (be[0] && be[1]) begin
         upd[ppm_pkg::CTRL_LO_LSB +: ppm_pkg::LANE_W] = wd[ppm_pkg::MASK_LO_LSB +: ppm_pkg::LANE_W];
      end
      if (be[2] && be[3]) begin
         upd[ppm_pkg::CTRL_HI_LSB +: ppm_pkg::LANE_W] = wd[ppm_pkg::MASK_HI_LSB +: ppm_pkg::LANE_W];
      end
      upd = upd & wmask;
      return (old_val & ~upd) | (wd & upd);
   endfunction : ppm_masked_write

   assign bus_req = avs_read || avs_write;
   assign wr_go = avs_write && !avs_waitrequest;

   always_comb begin
      case (avs_address)
         ppm_pkg::OFS_CAPTURE_PULSE_LO: rd_mux = mux_control_capture_pulse_lo;
         ppm_pkg::OFS_SERIAL_PORTS: rd_mux = mux_control_serial_ports;
         ppm_pkg::OFS_CAPTURE_PULSE_HI: rd_mux = mux_control_capture_pulse_hi;
         ppm_pkg::OFS_SECOND_UART: rd_mux = mux_control_second_uart;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_comb begin
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      if (bus_req && avs_waitrequest) begin
         next_waitrequest = 1'b0;
         next_readdata = avs_read ? rd_mux : 32'h00000000;
      end
      next_capture_pulse_lo = mux_control_capture_pulse_lo;
      next_serial_ports = mux_control_serial_ports;
      next_capture_pulse_hi = mux_control_capture_pulse_hi;
      next_second_uart = mux_control_second_uart;
      // unmapped writes fall through and change nothing
      if (wr_go) begin
         case (avs_address)
            ppm_pkg::OFS_CAPTURE_PULSE_LO: next_capture_pulse_lo = ppm_masked_write(mux_control_capture_pulse_lo,
               avs_writedata, avs_byteenable, ppm_pkg::WMASK_CAPTURE_PULSE_LO);
            ppm_pkg::OFS_SERIAL_PORTS: next_serial_ports = ppm_masked_write(mux_control_serial_ports,
               avs_writedata, avs_byteenable, ppm_pkg::WMASK_SERIAL_PORTS);
            ppm_pkg::OFS_CAPTURE_PULSE_HI: next_capture_pulse_hi = ppm_masked_write(mux_control_capture_pulse_hi,
               avs_writedata, avs_byteenable, ppm_pkg::WMASK_CAPTURE_PULSE_HI);
            ppm_pkg::OFS_SECOND_UART: next_second_uart = ppm_masked_write(mux_control_second_uart,
               avs_writedata, avs_byteenable, ppm_pkg::WMASK_SECOND_UART);
            default: next_capture_pulse_lo = mux_control_capture_pulse_lo;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         mux_control_capture_pulse_lo <= ppm_pkg::REG_RESET;
         mux_control_serial_ports <= ppm_pkg::REG_RESET;
         mux_control_capture_pulse_hi <= ppm_pkg::REG_RESET;
         mux_control_second_uart <= ppm_pkg::REG_RESET;
      end else begin
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
         mux_control_capture_pulse_lo <= next_capture_pulse_lo;
         mux_control_serial_ports <= next_serial_ports;
         mux_control_capture_pulse_hi <= next_capture_pulse_hi;
         mux_control_second_uart <= next_second_uart;
      end
   end

   // fields
   logic amp_out_port_select;
   logic amp_out_enable;
   logic comparator_out_enable;
   logic [2:0] capture_input_select;
   logic [2:0] pulse01_pin_select;
   logic pulse1_out_enable;
   logic pulse0_out_enable;
   logic [2:0] i2c_pin_select;
   logic i2c_pin_enable;
   logic [2:0] spi_group_select;
   logic spi_pin_enable;
   logic [2:0] uart_pin_select;
   logic uart_pin_enable;
   logic capture3_mode;
   logic [2:0] pulse23_pin_select;
   logic pulse3_out_enable;
   logic pulse2_out_enable;
   logic [2:0] uart_two_pin_select;
   logic uart_two_pin_enable;

   assign amp_out_port_select = mux_control_capture_pulse_lo[ppm_pkg::AMP_SEL_BIT];
   assign amp_out_enable = mux_control_capture_pulse_lo[ppm_pkg::AMP_EN_BIT];
   assign comparator_out_enable = mux_control_capture_pulse_lo[ppm_pkg::CMP_EN_BIT];
   assign capture_input_select = mux_control_capture_pulse_lo[ppm_pkg::CAP_SEL_LSB +: ppm_pkg::SEL_W];
   assign pulse01_pin_select = mux_control_capture_pulse_lo[ppm_pkg::PW01_SEL_LSB +: ppm_pkg::SEL_W];
   assign pulse1_out_enable = mux_control_capture_pulse_lo[ppm_pkg::PW1_EN_BIT];
   assign pulse0_out_enable = mux_control_capture_pulse_lo[ppm_pkg::PW0_EN_BIT];
   assign i2c_pin_select = mux_control_serial_ports[ppm_pkg::I2C_SEL_LSB +: ppm_pkg::SEL_W];
   assign i2c_pin_enable = mux_control_serial_ports[ppm_pkg::I2C_EN_BIT];
   assign spi_group_select = mux_control_serial_ports[ppm_pkg::SPI_SEL_LSB +: ppm_pkg::SEL_W];
   assign spi_pin_enable = mux_control_serial_ports[ppm_pkg::SPI_EN_BIT];
   assign uart_pin_select = mux_control_serial_ports[ppm_pkg::UART_SEL_LSB +: ppm_pkg::SEL_W];
   assign uart_pin_enable = mux_control_serial_ports[ppm_pkg::UART_EN_BIT];
   assign capture3_mode = mux_control_capture_pulse_hi[ppm_pkg::CAP3_MODE_BIT];
   assign pulse23_pin_select = mux_control_capture_pulse_hi[ppm_pkg::PW23_SEL_LSB +: ppm_pkg::SEL_W];
   assign pulse3_out_enable = mux_control_capture_pulse_hi[ppm_pkg::PW3_EN_BIT];
   assign pulse2_out_enable = mux_control_capture_pulse_hi[ppm_pkg::PW2_EN_BIT];
   assign uart_two_pin_select = mux_control_second_uart[ppm_pkg::UART2_SEL_LSB +: ppm_pkg::SEL_W];
   assign uart_two_pin_enable = mux_control_second_uart[ppm_pkg::UART2_EN_BIT];

   // pin input synchroniser; filtered value moves only when stages two and three agree
   logic [ppm_pkg::SYNC_W-1:0] sync_a;
   logic [ppm_pkg::SYNC_W-1:0] sync_b;
   logic [ppm_pkg::SYNC_W-1:0] sync_c;
   logic [ppm_pkg::SYNC_W-1:0] filt;
   logic [ppm_pkg::SYNC_W-1:0] next_filt;
   logic [31:0] fpin;
   logic [3:0] falt;

   always_comb begin
      next_filt = filt;
      for (int k = 0; k < ppm_pkg::SYNC_W; k++) begin
         if (sync_b[k] == sync_c[k]) begin
            next_filt[k] = sync_c[k];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
         filt <= '0;
      end else begin
         sync_a <= {capture3_alt_in, pin_in};
         sync_b <= sync_a;
         sync_c <= sync_b;
         filt <= next_filt;
      end
   end

   assign fpin = filt[ppm_pkg::PIN_N-1:0];
   assign falt = filt[ppm_pkg::SYNC_W-1:ppm_pkg::PIN_N];

   // pin resolution
   logic [31:0] next_pin_out;
   logic [31:0] next_pin_oe;
   logic [1:0] next_amp_out;
   logic [1:0] next_amp_oe;

   always_comb begin
      logic [4:0] pi;
      pi = 5'h00;
      next_pin_out = 32'h00000000;
      next_pin_oe = 32'h00000000;
      for (int i = 0; i < ppm_pkg::PIN_N; i++) begin
         pi = 5'(i);
         if (spi_pin_enable && pi[4:2] == spi_group_select) begin
            case (pi[1:0])
               2'h0: begin
                  next_pin_out[i] = spi_cs_out;
                  next_pin_oe[i] = spi_cs_oe;
               end
               2'h1: begin
                  next_pin_out[i] = spi_ck_out;
                  next_pin_oe[i] = spi_ck_oe;
               end
               2'h2: begin
                  next_pin_out[i] = spi_miso_out;
                  next_pin_oe[i] = spi_miso_oe;
               end
               default: begin
                  next_pin_out[i] = spi_mosi_out;
                  next_pin_oe[i] = spi_mosi_oe;
               end
            endcase
         end else if (i2c_pin_enable && !pi[4] && pi[3:1] == i2c_pin_select) begin
            // open drain: only ever pulls low
            next_pin_out[i] = 1'b0;
            next_pin_oe[i] = pi[0] ? i2c_sda_drive_low : i2c_scl_drive_low;
         end else if (uart_pin_enable && pi[4:2] == uart_pin_select && !pi[1]) begin
            next_pin_out[i] = uart_tx;
            next_pin_oe[i] = !pi[0];
         end else if (uart_two_pin_enable && pi[4:2] == uart_two_pin_select && pi[1]) begin
            next_pin_out[i] = uart_two_tx;
            next_pin_oe[i] = !pi[0];
         end else if (comparator_out_enable && pi == ppm_pkg::CMP_PIN) begin
            next_pin_out[i] = comparator_out;
            next_pin_oe[i] = 1'b1;
         end else if (analog_claim[i]) begin
            next_pin_oe[i] = 1'b0;
         end else if (pi[4:2] == pulse01_pin_select && !pi[1]
                      && (pi[0] ? pulse1_out_enable : pulse0_out_enable)) begin
            next_pin_out[i] = pulse_out[pi[0]];
            next_pin_oe[i] = 1'b1;
         end else if (pi[4:2] == pulse23_pin_select && pi[1]
                      && (pi[0] ? pulse3_out_enable : pulse2_out_enable)) begin
            next_pin_out[i] = pulse_out[{1'b1, pi[0]}];
            next_pin_oe[i] = 1'b1;
         end else begin
            next_pin_out[i] = gpio_out[i];
            next_pin_oe[i] = gpio_oe[i];
         end
      end
      next_amp_out = {2{amp_digital_out}};
      next_amp_oe = 2'h0;
      if (amp_out_enable) begin
         next_amp_oe[amp_out_port_select] = 1'b1;
      end
   end

   // inputs returned to peripherals; capture watches pins whatever drives them
   logic next_spi_cs_in;
   logic next_spi_ck_in;
   logic next_spi_miso_in;
   logic next_spi_mosi_in;
   logic next_scl_in;
   logic next_sda_in;
   logic next_uart_rx;
   logic next_uart_two_rx;
   logic next_cap1;
   logic next_cap2;
   logic next_cap3;

   always_comb begin
      next_spi_cs_in = spi_pin_enable && fpin[{spi_group_select, 2'h0}];
      next_spi_ck_in = spi_pin_enable && fpin[{spi_group_select, 2'h1}];
      next_spi_miso_in = spi_pin_enable && fpin[{spi_group_select, 2'h2}];
      next_spi_mosi_in = spi_pin_enable && fpin[{spi_group_select, 2'h3}];
      next_scl_in = i2c_pin_enable ? fpin[{1'b0, i2c_pin_select, 1'b0}] : ppm_pkg::I2C_IDLE;
      next_sda_in = i2c_pin_enable ? fpin[{1'b0, i2c_pin_select, 1'b1}] : ppm_pkg::I2C_IDLE;
      next_uart_rx = uart_pin_enable ? fpin[{uart_pin_select, 2'h1}] : ppm_pkg::UART_RX_IDLE;
      next_uart_two_rx = uart_two_pin_enable ? fpin[{uart_two_pin_select, 2'h3}] : ppm_pkg::UART_RX_IDLE;
      next_cap1 = fpin[{1'b0, capture_input_select, 1'b0}];
      next_cap2 = fpin[{1'b0, capture_input_select, 1'b1}];
      if (!capture3_mode) begin
         next_cap3 = next_cap1;
      end else if (!capture_input_select[2]) begin
         next_cap3 = falt[capture_input_select[1:0]];
      end else begin
         next_cap3 = fpin[{ppm_pkg::CAP3_HI_PORT, capture_input_select[1:0], 1'b1}];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_out <= 32'h00000000;
         pin_oe <= 32'h00000000;
         amp_pin_out <= 2'h0;
         amp_pin_oe <= 2'h0;
         spi_cs_in <= 1'b0;
         spi_ck_in <= 1'b0;
         spi_miso_in <= 1'b0;
         spi_mosi_in <= 1'b0;
         i2c_scl_in <= ppm_pkg::I2C_IDLE;
         i2c_sda_in <= ppm_pkg::I2C_IDLE;
         uart_rx <= ppm_pkg::UART_RX_IDLE;
         uart_two_rx <= ppm_pkg::UART_RX_IDLE;
         capture_input_one <= 1'b0;
         capture_input_two <= 1'b0;
         capture_input_three <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         amp_pin_out <= next_amp_out;
         amp_pin_oe <= next_amp_oe;
         spi_cs_in <= next_spi_cs_in;
         spi_ck_in <= next_spi_ck_in;
         spi_miso_in <= next_spi_miso_in;
         spi_mosi_in <= next_spi_mosi_in;
         i2c_scl_in <= next_scl_in;
         i2c_sda_in <= next_sda_in;
         uart_rx <= next_uart_rx;
         uart_two_rx <= next_uart_two_rx;
         capture_input_one <= next_cap1;
         capture_input_two <= next_cap2;
         capture_input_three <= next_cap3;
      end
   end

   // checks
   sequence s_mask_zero_write;
      avs_write && !avs_waitrequest && avs_address == ppm_pkg::OFS_SERIAL_PORTS
         && avs_writedata[ppm_pkg::MASK_LO_LSB +: ppm_pkg::LANE_W] == 8'h00;
   endsequence

   sequence s_higher_off;
      !spi_pin_enable && !i2c_pin_enable;
   endsequence

   property p_spi_claim;
      @(posedge mclk) disable iff (rst)
      spi_pin_enable |=> pin_oe[{$past(spi_group_select), 2'h1}] == $past(spi_ck_oe)
         && pin_out[{$past(spi_group_select), 2'h1}] == $past(spi_ck_out);
   endproperty
   a_spi_claim: assert property (p_spi_claim) else $error("spi clock pin not driven by spi");

   property p_i2c_claim;
      @(posedge mclk) disable iff (rst)
      i2c_pin_enable && !spi_pin_enable |=> pin_oe[{1'b0, $past(i2c_pin_select), 1'b0}] == $past(i2c_scl_drive_low)
         && !pin_out[{1'b0, $past(i2c_pin_select), 1'b0}];
   endproperty
   a_i2c_claim: assert property (p_i2c_claim) else $error("i2c clock pin not open drain");

   property p_uart_tx;
      @(posedge mclk) disable iff (rst)
      s_higher_off ##0 uart_pin_enable |=> pin_oe[{$past(uart_pin_select), 2'h0}]
         && pin_out[{$past(uart_pin_select), 2'h0}] == $past(uart_tx)
         && !pin_oe[{$past(uart_pin_select), 2'h1}];
   endproperty
   a_uart_tx: assert property (p_uart_tx) else $error("uart pair wrong");

   property p_uart_two_tx;
      @(posedge mclk) disable iff (rst)
      s_higher_off ##0 uart_two_pin_enable && !uart_pin_enable |=> pin_oe[{$past(uart_two_pin_select), 2'h2}]
         && pin_out[{$past(uart_two_pin_select), 2'h2}] == $past(uart_two_tx);
   endproperty
   a_uart_two_tx: assert property (p_uart_two_tx) else $error("second uart tx wrong");

   property p_amp_pin;
      @(posedge mclk) disable iff (rst)
      amp_out_enable |=> amp_pin_oe[$past(amp_out_port_select)] && !amp_pin_oe[!$past(amp_out_port_select)];
   endproperty
   a_amp_pin: assert property (p_amp_pin) else $error("amp output pin wrong");

   property p_amp_off;
      @(posedge mclk) disable iff (rst)
      !amp_out_enable [*2] |-> amp_pin_oe == 2'h0;
   endproperty
   a_amp_off: assert property (p_amp_off) else $error("amp pin driven while disabled");

   property p_cmp_pin;
      @(posedge mclk) disable iff (rst)
      s_higher_off ##0 comparator_out_enable && !uart_two_pin_enable && !uart_pin_enable
         |=> pin_oe[ppm_pkg::CMP_PIN] && pin_out[ppm_pkg::CMP_PIN] == $past(comparator_out);
   endproperty
   a_cmp_pin: assert property (p_cmp_pin) else $error("comparator not on its pin");

   property p_pulse0;
      @(posedge mclk) disable iff (rst)
      s_higher_off ##0 !uart_pin_enable && !uart_two_pin_enable && !comparator_out_enable
         && pulse0_out_enable && analog_claim == 32'h00000000
         |=> pin_oe[{$past(pulse01_pin_select), 2'h0}] && pin_out[{$past(pulse01_pin_select), 2'h0}] == $past(pulse_out[0]);
   endproperty
   a_pulse0: assert property (p_pulse0) else $error("pulse zero not on its pin");

   property p_mask_zero;
      @(posedge mclk) disable iff (rst)
      s_mask_zero_write |=> mux_control_serial_ports[ppm_pkg::CTRL_LO_LSB +: ppm_pkg::LANE_W]
         == $past(mux_control_serial_ports[ppm_pkg::CTRL_LO_LSB +: ppm_pkg::LANE_W]);
   endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("write without mask changed control");

   property p_cap3_follow;
      @(posedge mclk) disable iff (rst)
      !capture3_mode && !rst ##1 !rst |-> capture_input_three == capture_input_one;
   endproperty
   a_cap3_follow: assert property (p_cap3_follow) else $error("capture three not following one");

endmodule : ppm_pin_mux

// ### ppm_pkg.sv
// constants for the peripheral pin multiplexer: register offsets, field positions,
// writable-bit masks and pin indices.
// assumes a flat 32-pin index: port 1 = 0..7, port 2 = 8..15, port 8 = 16..23, port 9 = 24..31.
package ppm_pkg;

   // avalon byte addresses of the four control words
   localparam logic [7:0] OFS_CAPTURE_PULSE_LO = 8'h40;
   localparam logic [7:0] OFS_SERIAL_PORTS = 8'h44;
   localparam logic [7:0] OFS_CAPTURE_PULSE_HI = 8'h48;
   localparam logic [7:0] OFS_SECOND_UART = 8'h4C;

   localparam int ADDR_W = 8;
   localparam int PIN_N = 32;
   localparam int CAP3_ALT_N = 4;
   localparam int SYNC_W = PIN_N + CAP3_ALT_N;
   localparam int SEL_W = 3;
   localparam int LANE_W = 8;

   // byte lanes: control byte and its mask byte
   localparam int CTRL_LO_LSB = 0;
   localparam int MASK_LO_LSB = 8;
   localparam int CTRL_HI_LSB = 16;
   localparam int MASK_HI_LSB = 24;

   // control word zero
   localparam int AMP_SEL_BIT = 19;
   localparam int AMP_EN_BIT = 18;
   localparam int CMP_EN_BIT = 16;
   localparam int CAP_SEL_LSB = 5;
   localparam int PW01_SEL_LSB = 2;
   localparam int PW1_EN_BIT = 1;
   localparam int PW0_EN_BIT = 0;

   // serial ports word
   localparam int I2C_SEL_LSB = 17;
   localparam int I2C_EN_BIT = 16;
   localparam int SPI_SEL_LSB = 5;
   localparam int SPI_EN_BIT = 4;
   localparam int UART_SEL_LSB = 1;
   localparam int UART_EN_BIT = 0;

   // capture and pulse high word
   localparam int CAP3_MODE_BIT = 5;
   localparam int PW23_SEL_LSB = 2;
   localparam int PW3_EN_BIT = 1;
   localparam int PW2_EN_BIT = 0;

   // second uart word
   localparam int UART2_SEL_LSB = 1;
   localparam int UART2_EN_BIT = 0;

   // bits that storage keeps; everything else reads zero
   localparam logic [31:0] WMASK_CAPTURE_PULSE_LO = 32'h000D00FF;
   localparam logic [31:0] WMASK_SERIAL_PORTS = 32'h000F00FF;
   localparam logic [31:0] WMASK_CAPTURE_PULSE_HI = 32'h0000003F;
   localparam logic [31:0] WMASK_SECOND_UART = 32'h0000000F;
   localparam logic [31:0] REG_RESET = 32'h00000000;

   localparam logic [4:0] CMP_PIN = 5'h07;
   localparam logic [1:0] CAP3_HI_PORT = 2'h2;
   localparam logic UART_RX_IDLE = 1'b1;
   localparam logic I2C_IDLE = 1'b1;

endpackage : ppm_pkg

// ### ppm_pin_model.sv
// pad side of the shared pins: pads read back what the block drives
// assumes ext is the level an outside driver puts on undriven pads
`timescale 1ns/1ns
module ppm_pin_model (
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] ext,
   output logic [31:0] pin_in
);
   // undriven pads show the outside level, never the last driven value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : ppm_pin_model

// ### tb_top.sv
// testbench for the peripheral pin multiplexer: bus tasks and scenarios
// assumes ppm_pkg and ppm_pin_model are compiled first
`timescale 1ns/1ns
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
   logic mclk = 0;
   logic rst = 1;
   logic rd = 0;
   logic wr = 0;
   logic wreq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, ext = 32'hA55A3CC3, gout = 32'h00100000, goe = 32'h00100000;
   logic [17:0] pv = 18'h0;
   logic [31:0] q, rdat, pin_in, pin_out, pin_oe;
   logic [1:0] ampo, ampe;
   logic [31:0] ana = 32'h0;
   logic ci1, ci2, ci3, urx, u2rx, scli, sdai, mosii;
   int err_count = 0;
   int checked = 0;
   always #25 mclk = ~mclk;
   ppm_pin_model pm_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
   ppm_pin_mux dut_u (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .pin_in(pin_in), .capture3_alt_in(ext[27:24]), .pin_out(pin_out), .pin_oe(pin_oe),
      .amp_pin_out(ampo), .amp_pin_oe(ampe), .gpio_out(gout), .gpio_oe(goe), .analog_claim(ana),
      .spi_cs_out(pv[0]), .spi_cs_oe(pv[1]), .spi_ck_out(pv[2]), .spi_ck_oe(pv[3]),
      .spi_miso_out(pv[4]), .spi_miso_oe(pv[5]), .spi_mosi_out(pv[6]), .spi_mosi_oe(pv[7]),
      .spi_cs_in(), .spi_ck_in(), .spi_miso_in(), .spi_mosi_in(mosii), .i2c_scl_drive_low(pv[8]),
      .i2c_sda_drive_low(pv[9]), .i2c_scl_in(scli), .i2c_sda_in(sdai), .uart_tx(pv[10]), .uart_rx(urx),
      .uart_two_tx(pv[11]), .uart_two_rx(u2rx), .comparator_out(pv[12]), .amp_digital_out(pv[13]),
      .pulse_out(pv[17:14]), .capture_input_one(ci1), .capture_input_two(ci2), .capture_input_three(ci3));
   task automatic finish_test;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // one transfer, held until waitrequest is sampled low; pins settle one edge later, and the task waits two
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (wreq === 1'b0) break;
      end
      if (i == 20) begin
         err_count++;
         finish_test();
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : bus
   task automatic t_regs;
      bus(0, 8'h40, 0);
      `CHK("reset word", 32'h0, q)
      bus(1, 8'h4C, 32'h000000F5);
      bus(0, 8'h4C, 0);
      `CHK("masked write", 32'h0, q)
      bus(1, 8'h48, 32'h0000FF3F);
      bus(0, 8'h48, 0);
      `CHK("mask reads zero", 32'h0000003F, q)
      bus(1, 8'h50, 32'hFFFFFFFF);
      bus(0, 8'h50, 0);
      `CHK("unmapped", 32'h0, q)
      bus(1, 8'h48, 32'h0000FF00);
      pv <= 18'h00800;
      bus(1, 8'h4C, 32'h00000F01);
      `CHK("uart2 tx", 2'b11, {pin_out[2], pin_oe[2]})
      `CHK("uart2 rx", 1'b0, u2rx)
      bus(1, 8'h4C, 32'h00000F00);
      `CHK("uart2 off", 1'b0, pin_oe[2])
   endtask : t_regs
   task automatic t_serial;
      pv <= 18'h00003;
      gout <= 32'h000000F0;
      goe <= 32'h001000F0;
      bus(1, 8'h44, 32'h0000FF33);
      `CHK("spi cs", 2'b11, {pin_out[4], pin_oe[4]})
      `CHK("spi mosi", 2'b00, {pin_out[7], pin_oe[7]})
      `CHK("spi mosi in", 1'b1, mosii)
      bus(1, 8'h44, 32'h0000FF03);
      `CHK("uart tx", 2'b01, {pin_out[4], pin_oe[4]})
      pv <= 18'h00100;
      bus(1, 8'h44, 32'hFF05FF03);
      `CHK("i2c scl", 2'b01, {pin_out[4], pin_oe[4]})
      `CHK("i2c sda", 1'b0, pin_oe[5])
      `CHK("i2c in", 2'b00, {scli, sdai})
      `CHK("uart rx", 1'b0, urx)
   endtask : t_serial
   task automatic t_analog;
      pv <= 18'h03000;
      bus(1, 8'h48, 32'h0000FF06);
      bus(1, 8'h40, 32'hFF0DFF00);
      `CHK("comparator", 2'b11, {pin_out[7], pin_oe[7]})
      `CHK("amp pin", 3'b110, {ampo[1], ampe})
      bus(1, 8'h40, 32'hFF00FF00);
      `CHK("pulse3", 2'b01, {pin_out[7], pin_oe[7]})
      `CHK("amp off", 2'b00, ampe)
      `CHK("gpio pin", 2'b01, {pin_out[20], pin_oe[20]})
      ana <= 32'h00000080;
      repeat (2) @(posedge mclk);
      `CHK("analog release", 1'b0, pin_oe[7])
      ana <= 32'h0;
   endtask : t_analog
   // capture pins are undriven, so they show ext after the input filter settles
   task automatic t_capture;
      ext <= 32'h01004000;
      bus(1, 8'h40, 32'h0000FFE0);
      repeat (4) @(posedge mclk);
      `CHK("capture sel 7", 3'b101, {ci1, ci2, ci3})
      bus(1, 8'h48, 32'h0000FF26);
      `CHK("capture three own pin", 3'b100, {ci1, ci2, ci3})
      bus(1, 8'h44, 32'hFF00FF00);
      bus(1, 8'h44, 32'h00000011);
      bus(0, 8'h44, 0);
      `CHK("mask zero write", 32'h0, q)
      bus(1, 8'h40, 32'hFF01FF0D);
      `CHK("capture three alt pin", 2'b01, {ci1, ci3})
      `CHK("comparator alone", 2'b11, {pin_out[7], pin_oe[7]})
      bus(1, 8'h40, 32'hFF00FF0D);
      `CHK("pulse0", 2'b01, {pin_out[12], pin_oe[12]})
   endtask : t_capture
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_serial();
      t_analog();
      t_capture();
      finish_test();
   end
endmodule : tb_top
